//--- rtl/pcfm_channel_fault_manager.sv
// per-port fault supervision for a two-channel power port
// assumes analog comparator flags arrive asynchronously; timers for cut and limit live elsewhere
`timescale 1ns/1ps
`include "pcfm_params.svh"
module pcfm_channel_fault_manager
	import pcfm_pkg::*;
#(
	parameter logic [`PCFM_DIS_CNT_W-1:0] DIS_CYCLES = `PCFM_DIS_CNT_W'(`PCFM_DIS_CYCLES)
) (
	input  wire logic       clk_in,
	input  wire logic       sys_rst_in,
	input  wire logic       port_reset_in,
	input  wire logic [1:0] power_on_req_in,
	input  wire logic       dual_signature_in,
	input  wire logic       single_sig_channel_fault_mode_in,
	input  wire logic       auto_mode_in,
	input  wire logic       auto_hold_sel_in,
	input  wire logic       host_hold_sel_in,
	input  wire logic [1:0] dc_disconnect_en_in,
	input  wire logic [1:0] power_good_in,
	input  wire logic [1:0] below_hold_in,
	input  wire logic [1:0] cut_expired_in,
	input  wire logic [1:0] lim_expired_in,
	input  wire logic       police_en_in,
	input  wire logic       police_trip_in,
	input  wire logic       inrush_fail_in,
	output logic [1:0]      channel_on_out,
	output logic            gate_weak_pulldown_out,
	output logic            hold_current_threshold_out,
	output logic            failed_switch_fault_out,
	output logic            port_dis_fault_out,
	output logic            port_cut_fault_out,
	output logic            port_lim_fault_out,
	output logic            port_start_fault_out,
	output logic [1:0]      chan_dis_fault_out,
	output logic [1:0]      chan_cut_fault_out,
	output logic [1:0]      chan_lim_fault_out
);
	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic [1:0] pg_s1_q, pg_s2_q, bh_s1_q, bh_s2_q;
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pg_s1_q <= 2'h0;
			pg_s2_q <= 2'h0;
			bh_s1_q <= 2'h0;
			bh_s2_q <= 2'h0;
		end else begin
			pg_s1_q <= power_good_in;
			pg_s2_q <= pg_s1_q;
			bh_s1_q <= below_hold_in;
			bh_s2_q <= bh_s1_q;
		end
	end

	// ----------------------------------------
	// state and decode
	// ----------------------------------------
	pcfm_state_t state_q, state_d;
	logic [1:0]  on_q, on_d;
	logic [`PCFM_DIS_CNT_W-1:0] dis_cnt_q [`PCFM_NCH];
	logic [1:0]  dis_exp;
	logic        single_keep;
	logic        fsw_detect;
	logic [1:0]  chan_off;
	logic        port_off;
	logic        dis_port;
	logic [`PCFM_FSW_CNT_W-1:0] off_cnt_q;

	// failed switch only when neither channel powered; open switch never asserts power good
	assign fsw_detect  = (on_q == 2'h0) && (|pg_s2_q) && (state_q == PCFM_OFF) && // R1 R4 R18
		(off_cnt_q == `PCFM_FSW_CNT_W'(`PCFM_FSW_SETTLE));
	assign single_keep = !dual_signature_in && single_sig_channel_fault_mode_in;
	// only the dc hold disconnect exists here; no ac path at all
	assign dis_port    = dual_signature_in ? 1'b0 :
		(single_keep ? (&dis_exp) : (|dis_exp)); // R11 R13 R15
	assign port_off    = (police_en_in && police_trip_in) || dis_port ||
		(!dual_signature_in && !single_sig_channel_fault_mode_in &&
		 (|(cut_expired_in & on_q) || |(lim_expired_in & on_q))); // R12 R13 R16
	assign chan_off    = (cut_expired_in | lim_expired_in | (dual_signature_in ? dis_exp : 2'h0)) & on_q; // R14

	// ----------------------------------------
	// disconnect timers
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < `PCFM_NCH; g++) begin : g_dis
			assign dis_exp[g] = on_q[g] && dc_disconnect_en_in[g] && (dis_cnt_q[g] >= DIS_CYCLES); // R8 R10
			always_ff @(posedge clk_in or posedge sys_rst_in) begin
				if (sys_rst_in)
					dis_cnt_q[g] <= '0;
				else if (!on_q[g] || !bh_s2_q[g] || !dc_disconnect_en_in[g])
					dis_cnt_q[g] <= '0; // R9 R10
				else if (dis_cnt_q[g] < DIS_CYCLES)
					dis_cnt_q[g] <= dis_cnt_q[g] + `PCFM_DIS_CNT_W'(1); // R7
			end
		end
	endgenerate

	// ----------------------------------------
	// off settle counter
	// ----------------------------------------
	// synced power good lags the gate by two edges; a port just switched off must not look shorted
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			off_cnt_q <= `PCFM_FSW_CNT_W'(`PCFM_FSW_SETTLE);
		else if (on_q != 2'h0)
			off_cnt_q <= '0;
		else if (off_cnt_q < `PCFM_FSW_CNT_W'(`PCFM_FSW_SETTLE))
			off_cnt_q <= off_cnt_q + `PCFM_FSW_CNT_W'(1);
	end

	// ----------------------------------------
	// port state machine
	// ----------------------------------------
	always_comb begin
		state_d = state_q;
		on_d    = on_q;
		case (state_q)
			PCFM_OFF: begin
				if (fsw_detect) begin
					state_d = PCFM_FSW_BAD; // R1
					on_d    = 2'h0;
				end else if (|power_on_req_in && !inrush_fail_in) begin
					state_d = PCFM_ON;
					on_d    = power_on_req_in;
				end
			end
			PCFM_ON: begin
				if (port_off || inrush_fail_in) begin
					on_d = 2'h0; // R8 R12
				end else begin
					on_d = on_q & ~chan_off; // R8 R14
				end
				if (on_d == 2'h0)
					state_d = PCFM_OFF;
			end
			// only this port is held; nothing leaves this block to other ports
			PCFM_FSW_BAD: begin
				on_d = 2'h0; // R3
			end
			default: begin
				state_d = PCFM_OFF;
				on_d    = 2'h0;
			end
		endcase
		if (port_reset_in) begin
			state_d = PCFM_OFF; // R2
			on_d    = 2'h0;
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state_q <= PCFM_OFF;
			on_q    <= 2'h0;
		end else begin
			state_q <= state_d;
			on_q    <= on_d;
		end
	end

	// ----------------------------------------
	// fault flags, sticky until port reset
	// ----------------------------------------
	logic pcut, plim, pdis;
	assign pcut = |(cut_expired_in & on_q) || (police_en_in && police_trip_in && state_q == PCFM_ON); // R16
	assign plim = |(lim_expired_in & on_q);
	assign pdis = dis_port || (dual_signature_in && |dis_exp);

	logic       port_dis_d;
	logic       port_cut_d;
	logic       port_lim_d;
	logic       port_start_d;
	logic [1:0] chan_dis_d;
	logic [1:0] chan_cut_d;
	logic [1:0] chan_lim_d;
	logic       fsw_bad_d;
	logic       hold_sel_d;

	assign port_dis_d   = port_dis_fault_out | pdis; // R8
	assign port_cut_d   = port_cut_fault_out | pcut; // R16
	assign port_lim_d   = port_lim_fault_out | plim;
	assign port_start_d = port_start_fault_out | (inrush_fail_in && state_q != PCFM_FSW_BAD); // R4
	assign chan_dis_d   = chan_dis_fault_out | (pdis ? dis_exp : 2'h0); // R17
	assign chan_cut_d   = chan_cut_fault_out | (cut_expired_in & on_q); // R17
	assign chan_lim_d   = chan_lim_fault_out | (lim_expired_in & on_q); // R17
	assign fsw_bad_d    = (state_d == PCFM_FSW_BAD); // R1 R18
	assign hold_sel_d   = auto_mode_in ? auto_hold_sel_in : host_hold_sel_in; // R5 R6

	// ----------------------------------------
	// status outputs
	// ----------------------------------------
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			channel_on_out <= 2'h0;
		end else begin
			channel_on_out <= on_d;
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			gate_weak_pulldown_out <= 1'b0;
		end else begin
			gate_weak_pulldown_out <= fsw_bad_d; // R1
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			hold_current_threshold_out <= 1'b0;
		end else begin
			hold_current_threshold_out <= hold_sel_d; // R5
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			failed_switch_fault_out <= 1'b0;
		end else begin
			failed_switch_fault_out <= fsw_bad_d; // R1 R18
		end
	end

	// ----------------------------------------
	// sticky fault outputs
	// ----------------------------------------
	// port reset wins over a same-cycle event; the host clears and re-reads
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			port_dis_fault_out <= 1'b0;
		end else if (port_reset_in) begin
			port_dis_fault_out <= 1'b0;
		end else begin
			port_dis_fault_out <= port_dis_d;
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			port_cut_fault_out <= 1'b0;
		end else if (port_reset_in) begin
			port_cut_fault_out <= 1'b0;
		end else begin
			port_cut_fault_out <= port_cut_d;
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			port_lim_fault_out <= 1'b0;
		end else if (port_reset_in) begin
			port_lim_fault_out <= 1'b0;
		end else begin
			port_lim_fault_out <= port_lim_d;
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			port_start_fault_out <= 1'b0;
		end else if (port_reset_in) begin
			port_start_fault_out <= 1'b0;
		end else begin
			port_start_fault_out <= port_start_d;
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			chan_dis_fault_out <= 2'h0;
		end else if (port_reset_in) begin
			chan_dis_fault_out <= 2'h0;
		end else begin
			chan_dis_fault_out <= chan_dis_d;
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			chan_cut_fault_out <= 2'h0;
		end else if (port_reset_in) begin
			chan_cut_fault_out <= 2'h0;
		end else begin
			chan_cut_fault_out <= chan_cut_d;
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			chan_lim_fault_out <= 2'h0;
		end else if (port_reset_in) begin
			chan_lim_fault_out <= 2'h0;
		end else begin
			chan_lim_fault_out <= chan_lim_d;
		end
	end
endmodule

//--- rtl/pcfm_params.svh
// constants for the per-port channel fault manager
// assumes one 250 MHz clock; included by the top module only
// Function
// R1 - power-good on unpowered port: disable, weaken pull-down, flag
// R2 - host clears failed-switch fault by port/chip reset
// R3 - failed-switch fault touches only its own port
// R4 - missing switch gives inrush fault, not failed-switch
// R5 - auto mode picks hold threshold; else host programs
// R6 - host picks 7.5mA single-channel class 0-4, else 3.5mA
// R7 - disconnect timer advances while current below hold
// R8 - disconnect expiry removes power and flags fault
// R9 - current above hold resets disconnect timer
// R10 - disconnect enable cleared stops disconnect removal
// R11 - no ac disconnect; only dc hold disconnect
// R12 - per-channel timers; expiry decides which channels off
// R13 - single sig, mode 0: port off; dual: channel
// R14 - mode 1: cut or limit fault offs one channel
// R15 - mode 1 disconnect: port off after both expire
// R16 - power police trip: cut event, whole port off
// R17 - keep per-channel fault flags besides port flags
// R18 - failed-switch check runs continuously while unpowered
`ifndef PCFM_PARAMS_SVH
`define PCFM_PARAMS_SVH
`define PCFM_CLK_MHZ       250
`define PCFM_DIS_TIME_US   350
`define PCFM_DIS_CYCLES    (`PCFM_DIS_TIME_US * `PCFM_CLK_MHZ)
`define PCFM_DIS_CNT_W     17
`define PCFM_NCH           2
`define PCFM_FSW_SETTLE    2
`define PCFM_FSW_CNT_W     2
`endif

//--- rtl/pcfm_pkg.sv
// types shared by the channel fault manager
// assumes the params header is on the include path
package pcfm_pkg;
	typedef enum logic [1:0] {
		PCFM_OFF,
		PCFM_ON,
		PCFM_FSW_BAD
	} pcfm_state_t;
endpackage

//--- verif/pcfm_pd_model.sv
// far-side model: a powered device on two pairsets
// assumes channel enables come straight from the design
`timescale 1ns/1ps
module pcfm_pd_model (
	input  wire logic [1:0] on_in,
	input  wire logic [1:0] draw_in,
	input  wire logic [1:0] short_in,
	output logic [1:0]      pg_out,
	output logic [1:0]      low_out
);
	// a shorted switch shows power good with the gate off
	assign pg_out  = on_in | short_in;
	// an unpowered channel carries no current, so it reads below hold
	assign low_out = ~(on_in & draw_in);
endmodule

//--- verif/pcfm_asserts.sv
// port checker for the channel fault manager
// assumes bind onto the design top, one clock domain
`timescale 1ns/1ps
module pcfm_asserts (
	input wire logic       clk_in, sys_rst_in, port_reset_in, dual_signature_in, auto_mode_in,
	input wire logic       single_sig_channel_fault_mode_in, auto_hold_sel_in, host_hold_sel_in,
	input wire logic       police_en_in, police_trip_in, inrush_fail_in, failed_switch_fault_out,
	input wire logic       gate_weak_pulldown_out, hold_current_threshold_out, port_cut_fault_out,
	input wire logic       port_start_fault_out, port_dis_fault_out,
	input wire logic [1:0] power_good_in, cut_expired_in, lim_expired_in, channel_on_out,
	input wire logic [1:0] chan_dis_fault_out, chan_lim_fault_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	wire ss  = !dual_signature_in && !port_reset_in;
	wire fm  = single_sig_channel_fault_mode_in;
	wire on2 = channel_on_out == 2'h3;
	fsw_flag_a: assert property ((channel_on_out == 2'h0 && |power_good_in && !port_reset_in)[*3]
		|-> ##[0:1] failed_switch_fault_out) else $error("failed switch not flagged");
	fsw_pull_a: assert property (failed_switch_fault_out |-> gate_weak_pulldown_out && channel_on_out == 2'h0)
		else $error("failed switch port not disabled");
	fsw_cause_a: assert property ($rose(failed_switch_fault_out) |->
		$past(channel_on_out, 3) == 2'h0 && $past(power_good_in, 3) != 2'h0) else $error("spurious failed switch");
	start_a: assert property (inrush_fail_in && |channel_on_out && !port_reset_in |=>
		channel_on_out == 2'h0 && port_start_fault_out && !failed_switch_fault_out) else $error("inrush fail");
	hold_sel_a: assert property ($stable({auto_mode_in, auto_hold_sel_in, host_hold_sel_in})[*2] |->
		hold_current_threshold_out == (auto_mode_in ? auto_hold_sel_in : host_hold_sel_in)) else $error("hold");
	cut_port_a: assert property (ss && !fm && on2 && |cut_expired_in |=> channel_on_out == 2'h0)
		else $error("cut did not drop port");
	lim_chan_a: assert property (ss && fm && on2 && lim_expired_in == 2'h2 |=>
		!channel_on_out[1] && chan_lim_fault_out[1]) else $error("limit channel");
	police_a: assert property (police_en_in && police_trip_in && |channel_on_out && !port_reset_in |=>
		channel_on_out == 2'h0 && port_cut_fault_out) else $error("policing did not drop port");
	dis_flag_a: assert property ($rose(chan_dis_fault_out[0]) && dual_signature_in |-> !channel_on_out[0])
		else $error("disconnect flag with channel on");
	cover property (failed_switch_fault_out);
	cover property ($fell(channel_on_out[0]) && channel_on_out[1]);
	cover property ($rose(port_dis_fault_out));
endmodule
bind pcfm_channel_fault_manager pcfm_asserts u_chk (.*);

//--- verif/pcfm_channel_fault_manager_bench.sv
// self-checking bench for the channel fault manager
// assumes a 4 ns clock and a disconnect count cut to 20
`timescale 1ns/1ps
module pcfm_channel_fault_manager_bench;
	logic       clk_in, sys_rst_in, port_reset_in, dual_signature_in, single_sig_channel_fault_mode_in;
	logic       auto_mode_in, auto_hold_sel_in, host_hold_sel_in, police_en_in, police_trip_in, inrush_fail_in;
	logic       gate_weak_pulldown_out, hold_current_threshold_out, failed_switch_fault_out;
	logic       port_dis_fault_out, port_cut_fault_out, port_lim_fault_out, port_start_fault_out;
	logic [1:0] power_on_req_in, dc_disconnect_en_in, power_good_in, below_hold_in, cut_expired_in, draw;
	logic [1:0] lim_expired_in, channel_on_out, chan_dis_fault_out, chan_cut_fault_out, chan_lim_fault_out, sh;
	int         error_cnt = 0, checks = 0, cyc = 0;
	pcfm_channel_fault_manager #(.DIS_CYCLES(17'h14)) u_dut (.*);
	pcfm_pd_model u_pd (.on_in(channel_on_out), .draw_in(draw), .short_in(sh), .pg_out(power_good_in),
		.low_out(below_hold_in));
	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// hang guard, about eight times the planned run
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			error_cnt++;
			final_report();
		end
	end
	task automatic chk(string n, logic [1:0] e, logic [1:0] g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic w(int n);
		repeat (n) @(negedge clk_in);
	endtask
	task automatic pwr();
		power_on_req_in = 2'h3;
		w(1);
		power_on_req_in = 2'h0;
		w(4);
	endtask
	task automatic prst();
		port_reset_in = 1'b1;
		w(1);
		port_reset_in = 1'b0;
		w(1);
	endtask
	task automatic pulse(ref logic [1:0] s, input logic [1:0] v);
		s = v;
		w(1);
		s = 2'h0;
		w(2);
	endtask
	initial begin
		{port_reset_in, dual_signature_in, single_sig_channel_fault_mode_in, auto_mode_in, auto_hold_sel_in} = 5'h0;
		{host_hold_sel_in, police_en_in, police_trip_in, inrush_fail_in} = 4'h0;
		{power_on_req_in, cut_expired_in, lim_expired_in, sh} = 8'h0;
		{dc_disconnect_en_in, draw, sys_rst_in} = 5'h1f;
		w(3);
		sys_rst_in = 1'b0;
		w(2);
		auto_mode_in = 1'b1;
		auto_hold_sel_in = 1'b1;
		w(3);
		chk("hold_auto", 2'h1, {1'b0, hold_current_threshold_out});
		auto_mode_in = 1'b0;
		w(3);
		chk("hold_host", 2'h0, {1'b0, hold_current_threshold_out});
		pwr();
		pulse(cut_expired_in, 2'h1);
		chk("cut_on", 2'h0, channel_on_out);
		chk("cut_chan", 2'h1, chan_cut_fault_out);
		prst();
		$display("test hold and strict cut done");
		single_sig_channel_fault_mode_in = 1'b1;
		pwr();
		pulse(lim_expired_in, 2'h2);
		chk("lim_on", 2'h1, channel_on_out);
		chk("lim_chan", 2'h2, chan_lim_fault_out);
		chk("lim_port", 2'h1, {1'b0, port_lim_fault_out});
		prst();
		pwr();
		draw = 2'h1;
		w(30);
		chk("dis_one", 2'h3, channel_on_out);
		draw = 2'h0;
		w(30);
		chk("dis_both", 2'h0, channel_on_out);
		chk("dis_port", 2'h1, {1'b0, port_dis_fault_out});
		prst();
		$display("test channel mode done");
		{single_sig_channel_fault_mode_in, dual_signature_in, draw} = 4'h7;
		pwr();
		draw = 2'h2;
		w(14);
		draw = 2'h3;
		w(2);
		draw = 2'h2;
		w(14);
		chk("dis_rearm", 2'h3, channel_on_out);
		w(14);
		chk("dis_dual", 2'h2, channel_on_out);
		chk("dis_chan", 2'h1, chan_dis_fault_out);
		prst();
		{dc_disconnect_en_in, draw} = 4'h0;
		pwr();
		w(40);
		chk("dis_off", 2'h3, channel_on_out);
		{police_en_in, police_trip_in} = 2'h3;
		w(1);
		police_trip_in = 1'b0;
		w(2);
		chk("police", 2'h3, {channel_on_out == 2'h0, port_cut_fault_out});
		prst();
		{dc_disconnect_en_in, draw, dual_signature_in} = 5'h1e;
		pwr();
		inrush_fail_in = 1'b1;
		w(1);
		inrush_fail_in = 1'b0;
		w(2);
		chk("inrush", 2'h1, {failed_switch_fault_out, port_start_fault_out});
		prst();
		$display("test disconnect and policing done");
		sh = 2'h1;
		w(5);
		chk("fsw", 2'h3, {failed_switch_fault_out, gate_weak_pulldown_out});
		pwr();
		chk("fsw_refuse", 2'h0, channel_on_out);
		prst();
		w(4);
		chk("fsw_again", 2'h1, {1'b0, failed_switch_fault_out});
		sh = 2'h0;
		w(3);
		prst();
		w(4);
		pwr();
		chk("fsw_clear", 2'h3, {channel_on_out});
		$display("test failed switch done");
		final_report();
	end
endmodule
